// ===== hw/ees_pkg.sv
// ees_pkg: shared constants of the serial eeprom access sequencer.
// assumes a 100 MHz core clock and a bus master that owns scl.
package ees_pkg;
  // --------------------------------------------------------------
  // array geometry
  // --------------------------------------------------------------
  localparam int         ADDR_W      = 14;
  localparam int         PAGE_W      = 8;
  localparam int         OFS_W       = 6;
  localparam int         MEM_BYTES   = 16384;
  localparam int         PAGE_BYTES  = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // --------------------------------------------------------------
  // slave address byte
  // --------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE    = 4'ha;
  // --------------------------------------------------------------
  // bit counter positions and reset values
  // --------------------------------------------------------------
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_END     = 4'h9;
  localparam logic [6:0] CIDX_IDLE   = 7'h40;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         TICK_NS       = 1000;
  localparam int         TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  // internal_program_time, longest value
  localparam int         PROG_TIME_MS  = 5;
  localparam int         PROG_TICKS    = PROG_TIME_MS * 1000000 / TICK_NS;
endpackage : ees_pkg

// ===== hw/ees_sync.sv
// ees_sync: two-flop synchroniser for asynchronous pin inputs.
// assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/10ps
module ees_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // --------------------------------------------------------------
  // two stages, only the second is visible
  // --------------------------------------------------------------
  // reset fills both stages with the pin level: no false edge after release
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= din;
      sync_q <= din;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : ees_sync

// ===== hw/ees_prog_timer.sv
// ees_prog_timer: self-timed programming cycle with a 1 us timebase.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
module ees_prog_timer #(
  parameter int unsigned TICK_CYCLES = ees_pkg::TICK_CYCLES,
  parameter int unsigned PROG_TICKS  = ees_pkg::PROG_TICKS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);
  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        busy_q;
  logic        busy_d;
  logic        tick;

  // --------------------------------------------------------------
  // divider to timebase tick, tick counter to end of cycle
  // --------------------------------------------------------------
  always_comb begin
    pre_d  = pre_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    tick   = busy_q && (pre_q == 32'(TICK_CYCLES - 1));
    if (busy_q) begin
      pre_d = tick ? 32'h0 : pre_q + 32'h1;
    end
    if (tick) begin
      if (cnt_q == 32'(PROG_TICKS - 1)) begin // RULE23 RULE25
        busy_d = 1'b0;
        cnt_d  = 32'h0;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
    if (start && !busy_q) begin
      busy_d = 1'b1;
      pre_d  = 32'h0;
      cnt_d  = 32'h0;
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q  <= 32'h0;
      cnt_q  <= 32'h0;
      busy_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
endmodule : ees_prog_timer

// ===== hw/ees_top.sv
// ees_top: two-wire serial eeprom slave, 16k x 8 array, 64-byte page buffer.
// assumes scl, sda, write protect and chip selects arrive unsynchronised;
// sda is open drain: SDA_OE high pulls the line low, the bench resolves it.
`timescale 1ns/10ps
//
// Contract
// [RULE1] write-direction address match: next two bytes load the address counter.
// [RULE2] top two address bits ignored, eight pick page, six pick byte.
// [RULE3] bytes after the address go to the page buffer, later to array.
// [RULE4] acknowledge slave address, both address bytes and each write data byte.
// [RULE5] master starts programming with stop after the last data byte.
// [RULE6] during programming sda stays released and requests are ignored.
// [RULE7] up to 64 bytes are programmed together in one cycle.
// [RULE8] page loading keeps page fixed, offset wraps inside the page.
// [RULE9] programming writes latest buffer contents, only bytes of this sequence.
// [RULE10] slave address is not acknowledged while programming runs.
// [RULE11] write protect high blocks all writes, low has no effect.
// [RULE12] write protect sampled on falling edge just before first data byte.
// [RULE13] sampled protect high: data byte not acknowledged, write discarded.
// [RULE14] every array byte starts erased at ff.
// [RULE15] read-direction match: acknowledge and shift out byte at counter.
// [RULE16] after a read byte wait for master; nack then stop gives standby.
// [RULE17] random read: address bytes then restart in read direction.
// [RULE18] master acknowledge continues reading from following locations.
// [RULE19] sequential read counter wraps at end of array, not page.
// [RULE20] slave address is type 1010, chip select levels, direction bit.
// [RULE21] receiver acknowledges low on ninth clock; reading device releases then.
// [RULE22] sample data on scl rise, change output on scl fall.
// [RULE23] programming completes within five milliseconds, then address acknowledged again.
// [RULE24] stop with no data byte loaded updates address only, no programming.
// [RULE25] programming length is a configurable count of the internal timebase.
module ees_top #(
  parameter int unsigned PROG_TICKS = ees_pkg::PROG_TICKS
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  input  wire logic       WP,
  input  wire logic [2:0] CHIP_SELECT_PINS
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_RDAT, ST_SKIP
  } ees_state_t;

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [5:0]  pins_s;
  logic        scl_s, sda_s, wp_s;
  logic [2:0]  cs_s;
  logic        scl_q, sda_q;
  logic        rise, fall, start, stop, fall8, fall9;
  ees_state_t  st_q, st_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  rx_q, rx_d, tx_q, tx_d, hi_q, hi_d;
  logic [13:0] addr_q, addr_d;
  logic [7:0]  prog_page_q, prog_page_d;
  logic [6:0]  cidx_q, cidx_d;
  logic [63:0] vld_q, vld_d;
  logic        drv_q, drv_d, match_q, match_d, rd_q, rd_d;
  logic        wp_lat_q, wp_lat_d, pend_q, pend_d, mack_q, mack_d;
  logic        buf_we, cm_we, ld_rd, prog_go, busy;
  logic [7:0]  rd_byte;
  logic [7:0]  mem_q [ees_pkg::MEM_BYTES];
  logic [7:0]  page_q [ees_pkg::PAGE_BYTES];

  // slave address decode
  function automatic logic dev_hit(input logic [7:0] b, input logic [2:0] cs);
    dev_hit = (b[7:4] == ees_pkg::DEV_TYPE) && (b[3:1] == cs); // RULE20
  endfunction : dev_hit

  // --------------------------------------------------------------
  // pin synchronisers and programming timer
  // --------------------------------------------------------------
  ees_sync #(.W(6)) u_sync (
    .clk  (CLK),
    .rst  (RESET),
    .din  ({SCL, SDA_I, WP, CHIP_SELECT_PINS}),
    .dout (pins_s)
  );
  assign {scl_s, sda_s, wp_s, cs_s} = pins_s;

  ees_prog_timer #(.PROG_TICKS(PROG_TICKS)) u_timer (
    .clk   (CLK),
    .rst   (RESET),
    .start (prog_go),
    .busy  (busy)
  );

  // bus events from synchronised levels
  assign rise  = scl_s && !scl_q; // RULE22
  assign fall  = !scl_s && scl_q;
  assign start = scl_s && scl_q && sda_q && !sda_s;
  assign stop  = scl_s && scl_q && !sda_q && sda_s;
  assign fall8 = fall && (bit_q == ees_pkg::BIT_ACK);
  assign fall9 = fall && (bit_q == ees_pkg::BIT_END);
  assign rd_byte = mem_q[addr_q];
  assign cm_we   = busy && !cidx_q[6] && vld_q[cidx_q[5:0]];

  // --------------------------------------------------------------
  // next-state logic of the protocol sequencer
  // --------------------------------------------------------------
  always_comb begin
    st_d = st_q;  bit_d = bit_q;  rx_d = rx_q;  tx_d = tx_q;  hi_d = hi_q;
    addr_d = addr_q;  prog_page_d = prog_page_q;  cidx_d = cidx_q;
    vld_d = vld_q;  drv_d = drv_q;  match_d = match_q;  rd_d = rd_q;
    wp_lat_d = wp_lat_q;  pend_d = pend_q;  mack_d = mack_q;
    buf_we = 1'b0;  ld_rd = 1'b0;  prog_go = 1'b0;
    // rising edge: shift data in, or take master answer on ninth clock
    if (rise && (bit_q < ees_pkg::BIT_END)) begin
      bit_d = bit_q + 4'h1;
      if (bit_q < ees_pkg::BIT_ACK) begin
        rx_d = {rx_q[6:0], sda_s}; // RULE22
      end else begin
        mack_d = sda_s; // RULE16
      end
    end
    // falling edge after eighth bit: acknowledge decision
    if (fall8) begin
      drv_d = 1'b0; // RULE21
      unique case (st_q)
        ST_DEV: begin
          match_d = dev_hit(rx_q, cs_s) && !busy; // RULE10 RULE6
          rd_d    = rx_q[0];
          drv_d   = match_d; // RULE4
        end
        ST_AHI: begin
          hi_d  = rx_q;
          drv_d = 1'b1; // RULE4
        end
        ST_ALO: begin
          addr_d = {hi_q[5:0], rx_q}; // RULE1 RULE2 RULE17
          drv_d  = 1'b1;
          vld_d  = '0; // RULE9
          pend_d = 1'b0;
        end
        ST_WDAT: begin
          if (!wp_lat_q) begin
            buf_we = 1'b1; // RULE3 RULE7
            vld_d[addr_q[5:0]] = 1'b1;
            addr_d = {addr_q[13:6], addr_q[5:0] + 6'h1}; // RULE8
            pend_d = 1'b1;
            drv_d  = 1'b1; // RULE4
          end else begin
            pend_d = 1'b0; // RULE13 RULE11
            st_d   = ST_SKIP;
          end
        end
        ST_RDAT, ST_SKIP, ST_IDLE: drv_d = 1'b0;
      endcase
    end else if (fall9) begin
      // end of ninth clock: release and move on
      bit_d = 4'h0;
      drv_d = 1'b0;
      unique case (st_q)
        ST_DEV: begin
          if (!match_q) begin
            st_d = ST_SKIP;
          end else if (rd_q) begin
            st_d  = ST_RDAT;
            ld_rd = 1'b1; // RULE15
          end else begin
            st_d = ST_AHI;
          end
        end
        ST_AHI: st_d = ST_ALO;
        ST_ALO: begin
          st_d     = ST_WDAT;
          wp_lat_d = wp_s; // RULE12
        end
        ST_RDAT: begin
          if (!mack_q) begin
            ld_rd = 1'b1; // RULE18
          end else begin
            st_d = ST_SKIP; // RULE16
          end
        end
        ST_WDAT, ST_SKIP, ST_IDLE: st_d = st_q;
      endcase
      if (ld_rd) begin
        tx_d   = rd_byte;
        addr_d = addr_q + 14'h1; // RULE19
        drv_d  = !rd_byte[7];
      end
    end else if (fall && (st_q == ST_RDAT) && (bit_q != 4'h0)) begin
      // data bits change on scl fall
      tx_d  = {tx_q[6:0], 1'b0};
      drv_d = !tx_q[6]; // RULE22
    end
    // start and stop override bit handling
    if (start) begin
      st_d    = ST_DEV;
      bit_d   = 4'h0;
      drv_d   = 1'b0;
      match_d = 1'b0;
    end else if (stop) begin
      if ((st_q == ST_WDAT) && pend_q && !wp_lat_q && !busy) begin // RULE24
        prog_go     = 1'b1; // RULE5
        prog_page_d = addr_q[13:6];
        cidx_d      = 7'h0;
      end
      st_d   = ST_IDLE; // RULE16
      drv_d  = 1'b0;
      pend_d = 1'b0;
    end
    // commit walk over the page buffer during programming
    if (busy && !cidx_q[6]) begin
      cidx_d = cidx_q + 7'h1; // RULE9
    end
  end

  // --------------------------------------------------------------
  // sequencer registers
  // --------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= ST_IDLE;  bit_q <= 4'h0;  rx_q <= 8'h00;  tx_q <= 8'h00;
      hi_q <= 8'h00;  addr_q <= 14'h0000;  prog_page_q <= 8'h00;
      cidx_q <= ees_pkg::CIDX_IDLE;  vld_q <= '0;  drv_q <= 1'b0;
      match_q <= 1'b0;  rd_q <= 1'b0;  wp_lat_q <= 1'b0;  pend_q <= 1'b0;
      mack_q <= 1'b1;  scl_q <= scl_s;  sda_q <= sda_s; // edge memory takes idle pin level
    end else begin
      st_q <= st_d;  bit_q <= bit_d;  rx_q <= rx_d;  tx_q <= tx_d;
      hi_q <= hi_d;  addr_q <= addr_d;  prog_page_q <= prog_page_d;
      cidx_q <= cidx_d;  vld_q <= vld_d;  drv_q <= drv_d;
      match_q <= match_d;  rd_q <= rd_d;  wp_lat_q <= wp_lat_d;
      pend_q <= pend_d;  mack_q <= mack_d;  scl_q <= scl_s;  sda_q <= sda_s;
    end
  end

  // --------------------------------------------------------------
  // array and page buffer storage
  // --------------------------------------------------------------
  initial begin
    for (int i = 0; i < ees_pkg::MEM_BYTES; i++) begin
      mem_q[i] = ees_pkg::ERASED_BYTE; // RULE14
    end
  end

  // buffer load and page commit; plain always, the array is also preset above
  always @(posedge CLK) begin
    if (buf_we) begin
      page_q[addr_q[5:0]] <= rx_q; // RULE3
    end
    if (cm_we) begin
      mem_q[{prog_page_q, cidx_q[5:0]}] <= page_q[cidx_q[5:0]]; // RULE7 RULE9
    end
  end

  assign SDA_O  = 1'b0;
  assign SDA_OE = drv_q;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  property p_busy_quiet;
    @(posedge CLK) disable iff (RESET) busy |-> !SDA_OE;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("sda driven while busy"); // RULE6

  property p_poll_nack;
    @(posedge CLK) disable iff (RESET)
      (fall8 && (st_q == ST_DEV) && busy) |=> !SDA_OE && !match_q;
  endproperty
  a_poll_nack: assert property (p_poll_nack) else $error("address acked while busy"); // RULE10

  property p_dev_ack;
    @(posedge CLK) disable iff (RESET)
      (fall8 && (st_q == ST_DEV) && !busy && dev_hit(rx_q, cs_s)) |=> SDA_OE;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("matching address not acked"); // RULE20

  property p_wp_reject;
    @(posedge CLK) disable iff (RESET)
      (fall8 && (st_q == ST_WDAT) && wp_lat_q) |=> !SDA_OE && (st_q == ST_SKIP) && !pend_q;
  endproperty
  a_wp_reject: assert property (p_wp_reject) else $error("protected write accepted"); // RULE13

  property p_wp_sample;
    @(posedge CLK) disable iff (RESET)
      (fall9 && (st_q == ST_ALO)) |=> (wp_lat_q == $past(wp_s));
  endproperty
  a_wp_sample: assert property (p_wp_sample) else $error("protect not sampled"); // RULE12

  property p_addr_load;
    @(posedge CLK) disable iff (RESET)
      (fall8 && (st_q == ST_ALO)) |=> (addr_q == {$past(hi_q[5:0]), $past(rx_q)});
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address counter not loaded"); // RULE2

  property p_page_hold;
    @(posedge CLK) disable iff (RESET)
      buf_we |=> (addr_q[13:6] == $past(addr_q[13:6]))
                 && (addr_q[5:0] == 6'($past(addr_q[5:0]) + 6'h1));
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page offset wrong"); // RULE8

  property p_seq_wrap;
    @(posedge CLK) disable iff (RESET)
      ld_rd |=> (addr_q == 14'($past(addr_q) + 14'h1)) && (SDA_OE == !tx_q[7]);
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("read counter step wrong"); // RULE19

  property p_prog_start;
    @(posedge CLK) disable iff (RESET)
      prog_go |=> busy && (cidx_q == 7'h00) ##64 cidx_q[6];
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("page commit not run"); // RULE9

  property p_no_empty;
    @(posedge CLK) disable iff (RESET) (stop && !pend_q && !busy) |=> !busy;
  endproperty
  a_no_empty: assert property (p_no_empty) else $error("empty write programmed"); // RULE24

  c_prog:   cover property (@(posedge CLK) disable iff (RESET) prog_go);
  c_seq:    cover property (@(posedge CLK) disable iff (RESET) ld_rd && (st_q == ST_RDAT));
  c_poll:   cover property (@(posedge CLK) disable iff (RESET) fall8 && (st_q == ST_DEV) && busy);
  c_reject: cover property (@(posedge CLK) disable iff (RESET)
                            fall8 && (st_q == ST_WDAT) && wp_lat_q);
endmodule : ees_top

// ===== dv/ees_master.sv
// ees_master: behavioural two-wire bus master that faces the eeprom block.
// assumes its tasks are called right after a rising clk edge; sda has a pull-up.
`timescale 1ns/10ps
module ees_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // --------------------------------------------------------------
  // bus idle: clock high, data released
  // --------------------------------------------------------------
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // wait a number of core clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one scl period of 80 ns: data set in the low half, sampled late in the high half
  task automatic clk_bit(input logic b, output logic s);
    scl  <= 1'b0;
    cyc(2);
    pull <= ~b;
    cyc(2);
    scl  <= 1'b1;
    cyc(4);
    s = sda;
  endtask : clk_bit

  // start or repeated start: data falls while scl is high
  task automatic start();
    scl  <= 1'b0;
    cyc(2);
    pull <= 1'b0;
    cyc(2);
    scl  <= 1'b1;
    cyc(4);
    pull <= 1'b1;
    cyc(4);
  endtask : start

  // stop: data rises while scl is high, which launches programming after loaded write data
  task automatic stop();
    scl  <= 1'b0;
    cyc(2);
    pull <= 1'b1;
    cyc(2);
    scl  <= 1'b1;
    cyc(4);
    pull <= 1'b0;
    cyc(4);
  endtask : stop

  // send a byte msb first, release on the ninth clock and read the answer
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // receive a byte, then acknowledge it low or leave the line high
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~mack, s);
  endtask : rd_byte
endmodule : ees_master

// ===== dv/test_i2c_eeprom_rw_sequencer.sv
// test_i2c_eeprom_rw_sequencer: self-checking bench for the eeprom block.
// assumes a shortened programming time of 2 ticks and a pulled-up sda line.
`timescale 1ns/10ps
module test_i2c_eeprom_rw_sequencer;
  // --------------------------------------------------------------
  // clock, reset, pins and the resolved open-drain line
  // --------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wp  = 1'b0;
  logic [2:0] cs  = 3'h5;
  logic       scl;
  logic       pull;
  logic       sda_o;
  logic       sda_oe;
  wire        sda;
  int         mismatches = 0;
  int         checks = 0;
  int         cycles = 0;

  always #5 clk = ~clk;
  assign sda = !((sda_oe && !sda_o) || pull);

  ees_master i_mst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  ees_top #(.PROG_TICKS(2)) i_dut (
    .CLK(clk), .RESET(rst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .WP(wp), .CHIP_SELECT_PINS(cs)
  );

  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] dev(input logic rd);
    return {ees_pkg::DEV_TYPE, cs, rd};
  endfunction : dev

  // start, write-direction slave address and both address bytes
  task automatic send_addr(input logic [15:0] a);
    logic k;
    i_mst.start();
    i_mst.wr_byte(dev(1'b0), k);
    chk({7'h0, k}, 8'h01, "slave ack");
    i_mst.wr_byte(a[15:8], k);
    chk({7'h0, k}, 8'h01, "addr hi ack");
    i_mst.wr_byte(a[7:0], k);
    chk({7'h0, k}, 8'h01, "addr lo ack");
  endtask : send_addr

  // random read of two bytes from address a
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic       k;
    logic [7:0] d;
    send_addr(a);
    i_mst.start();
    i_mst.wr_byte(dev(1'b1), k);
    chk({7'h0, k}, 8'h01, "read ack");
    i_mst.rd_byte(1'b1, d);
    chk(d, e0, "first byte");
    i_mst.rd_byte(1'b0, d);
    chk(d, e1, "next byte");
    i_mst.stop();
  endtask : rd2

  // poll the slave address until acknowledged, bounded
  task automatic wait_ready(output logic k);
    int n;
    n = 0;
    do begin
      i_mst.start();
      i_mst.wr_byte(dev(1'b0), k);
      i_mst.stop();
      n++;
    end while (k !== 1'b1 && n < 40);
  endtask : wait_ready

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_erased();
    rd2(16'hc123, 8'hff, 8'hff);
  endtask : t_erased

  task automatic t_page();
    logic k;
    send_addr(16'h003e);
    for (int i = 0; i < 4; i++) begin
      i_mst.wr_byte(8'ha0 + 8'(i), k);
      chk({7'h0, k}, 8'h01, "data ack");
    end
    i_mst.stop();
    i_mst.start();
    i_mst.wr_byte(dev(1'b0), k);
    chk({7'h0, k}, 8'h00, "busy nack");
    i_mst.stop();
    wait_ready(k);
    chk({7'h0, k}, 8'h01, "ready again");
    rd2(16'h003e, 8'ha0, 8'ha1);
    rd2(16'h0000, 8'ha2, 8'ha3);
    rd2(16'h3fff, 8'hff, 8'ha2);
  endtask : t_page

  task automatic t_latest();
    logic k;
    send_addr(16'h0041);
    i_mst.wr_byte(8'h77, k);
    i_mst.stop();
    wait_ready(k);
    rd2(16'h0040, 8'hff, 8'h77);
  endtask : t_latest

  task automatic t_protect();
    logic k;
    wp <= 1'b1;
    send_addr(16'h0100);
    i_mst.wr_byte(8'h55, k);
    chk({7'h0, k}, 8'h00, "protected data nack");
    i_mst.stop();
    wp <= 1'b0;
    wait_ready(k);
    rd2(16'h0100, 8'hff, 8'hff);
  endtask : t_protect

  task automatic t_addr_only();
    logic       k;
    logic [7:0] d;
    send_addr(16'h0001);
    i_mst.stop();
    i_mst.start();
    i_mst.wr_byte(dev(1'b1), k);
    chk({7'h0, k}, 8'h01, "no programming after address");
    i_mst.rd_byte(1'b0, d);
    chk(d, 8'ha3, "immediate read");
    i_mst.stop();
    i_mst.start();
    i_mst.wr_byte({ees_pkg::DEV_TYPE, ~cs, 1'b0}, k);
    chk({7'h0, k}, 8'h00, "wrong select nack");
    i_mst.stop();
  endtask : t_addr_only

  // --------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_erased();
    t_page();
    t_latest();
    t_protect();
    t_addr_only();
    give_verdict();
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      $display("ERROR %0t timeout, run did not finish", $time);
      mismatches++;
      give_verdict();
    end
  end
endmodule : test_i2c_eeprom_rw_sequencer
